// *** core/rstg_top.sv ***
// Implementation choices: the placing of the registers and strobed register access.
`timescale 1ns/10ps
module rstg_top import rstg_pkg::*; (
	input wire logic I_REF_CLK,
	input wire logic I_NRST,
	input wire logic [7:0] I_ADDR,
	input wire logic [31:0] I_WDATA,
	input wire logic I_WR,
	input wire logic I_RD,
	output logic [31:0] O_RDATA,
	output logic O_FIRST_TRIGGER,
	output logic O_SECOND_TRIGGER
);
	rstg_timing_t first_output_timing_reg_ff;
	rstg_timing_t second_output_timing_reg_ff;
	rstg_end_counts_t sequence_end_counts_ff;
	logic req_le_ff;
	logic release_ff;
	logic warmdown_ff;
	rstg_seq_t seq_ff;
	rstg_seq_t nxt_seq;
	rstg_proto_t proto_ff;
	logic seq_is_tx_ff;
	logic [7:0] count_ff;
	logic [7:0] nxt_count;
	logic [1:0] le_phase_ff;
	logic [31:0] nxt_rdata;

	function automatic logic [7:0] wu_end(input rstg_end_counts_t e, input logic tx);
		wu_end = tx ? e.tx_warmup_end_count : e.rx_warmup_end_count;
	endfunction

	function automatic logic [7:0] wd_end(input rstg_end_counts_t e, input logic tx);
		wd_end = tx ? e.tx_warmdown_end_count : e.rx_warmdown_end_count;
	endfunction

	// Next trigger level from the compare points of the running sequence type.
	function automatic logic trig_next(input rstg_timing_t t, input logic tx,
			input logic [7:0] cnt, input logic cur);
		logic [7:0] hi;
		logic [7:0] lo;
		hi = tx ? t.tx_assert : t.rx_assert;
		lo = tx ? t.tx_deassert : t.rx_deassert;
		if (hi == QUIET_POINT && lo == QUIET_POINT) begin
			trig_next = cur;
		end else if (cnt == lo) begin
			trig_next = 1'b0;
		end else if (cnt == hi) begin
			trig_next = 1'b1;
		end else begin
			trig_next = cur;
		end
	endfunction

	always_ff @(posedge I_REF_CLK or negedge I_NRST) begin
		if (!I_NRST) begin
			first_output_timing_reg_ff <= RST_TIMING;
			second_output_timing_reg_ff <= RST_TIMING;
			sequence_end_counts_ff <= RST_END_COUNTS;
		end else if (I_WR) begin
			if (I_ADDR == ADDR_FIRST_TIMING) begin
				first_output_timing_reg_ff <= I_WDATA;
			end
			if (I_ADDR == ADDR_SECOND_TIMING) begin
				second_output_timing_reg_ff <= I_WDATA;
			end
			if (I_ADDR == ADDR_END_COUNTS) begin
				sequence_end_counts_ff <= I_WDATA;
			end
		end
	end

	// Control bits are one-shot requests; they self-clear after one cycle.
	always_ff @(posedge I_REF_CLK or negedge I_NRST) begin
		if (!I_NRST) begin
			req_le_ff <= 1'b0;
			release_ff <= 1'b0;
			warmdown_ff <= 1'b0;
		end else begin
			req_le_ff <= I_WR && I_ADDR == ADDR_CONTROL && I_WDATA[CTL_REQ_LE_BIT];
			release_ff <= I_WR && I_ADDR == ADDR_CONTROL && I_WDATA[CTL_RELEASE_BIT];
			warmdown_ff <= I_WR && I_ADDR == ADDR_CONTROL && I_WDATA[CTL_WARMDOWN_BIT];
		end
	end

	always_comb begin
		nxt_seq = seq_ff;
		nxt_count = count_ff;
		case (seq_ff)
			SEQ_IDLE: begin
				nxt_count = 8'h00;
				if (proto_ff != PROTO_HANDOVER) begin
					nxt_seq = SEQ_WARMUP;
				end
			end
			SEQ_WARMUP: begin
				if (count_ff >= wu_end(sequence_end_counts_ff, seq_is_tx_ff)) begin
					nxt_seq = SEQ_ON;
				end else begin
					nxt_count = 8'(count_ff + 8'h01);
				end
			end
			SEQ_ON: begin
				nxt_count = count_ff;
				if ((proto_ff == PROTO_MESH && req_le_ff) || warmdown_ff ||
						(proto_ff == PROTO_LE && release_ff)) begin
					nxt_seq = SEQ_WARMDOWN;
				end
			end
			SEQ_WARMDOWN: begin
				// Counting on from the held count gives a warm-down of wd_end - wu_end + 1 ticks.
				if (count_ff >= wd_end(sequence_end_counts_ff, seq_is_tx_ff)) begin
					nxt_seq = SEQ_HALT;
				end else begin
					nxt_count = 8'(count_ff + 8'h01);
				end
			end
			SEQ_HALT: begin
				nxt_seq = SEQ_IDLE;
				nxt_count = 8'h00;
			end
			default: begin
				nxt_seq = SEQ_IDLE;
				nxt_count = 8'h00;
			end
		endcase
	end

	always_ff @(posedge I_REF_CLK or negedge I_NRST) begin
		if (!I_NRST) begin
			seq_ff <= SEQ_IDLE;
			count_ff <= 8'h00;
		end else begin
			seq_ff <= nxt_seq;
			count_ff <= nxt_count;
		end
	end

	// Protocol owner and sequence type; the mesh side always receives.
	always_ff @(posedge I_REF_CLK or negedge I_NRST) begin
		if (!I_NRST) begin
			proto_ff <= PROTO_MESH;
			seq_is_tx_ff <= 1'b0;
			le_phase_ff <= 2'd0;
		end else if (seq_ff == SEQ_HALT) begin
			case (proto_ff)
				PROTO_MESH: begin
					if (le_phase_ff == 2'd1) begin
						proto_ff <= PROTO_HANDOVER;
					end else begin
						seq_is_tx_ff <= 1'b0;
					end
				end
				PROTO_LE: begin
					if (le_phase_ff == 2'd3) begin
						proto_ff <= PROTO_MESH;
						seq_is_tx_ff <= 1'b0;
						le_phase_ff <= 2'd0;
					end else begin
						seq_is_tx_ff <= 1'b1;
						le_phase_ff <= 2'd3;
					end
				end
				default: begin
					proto_ff <= PROTO_MESH;
				end
			endcase
		end else if (seq_ff == SEQ_ON && proto_ff == PROTO_MESH && req_le_ff) begin
			le_phase_ff <= 2'd1;
		end else if (seq_ff == SEQ_ON && proto_ff == PROTO_LE && release_ff) begin
			le_phase_ff <= 2'd3;
		end else if (proto_ff == PROTO_HANDOVER) begin
			proto_ff <= PROTO_LE;
			seq_is_tx_ff <= 1'b0;
			le_phase_ff <= 2'd2;
		end
	end

	always_ff @(posedge I_REF_CLK or negedge I_NRST) begin
		if (!I_NRST) begin
			O_FIRST_TRIGGER <= 1'b0;
			O_SECOND_TRIGGER <= 1'b0;
		end else if (seq_ff == SEQ_IDLE || seq_ff == SEQ_HALT) begin
			O_FIRST_TRIGGER <= 1'b0;
			O_SECOND_TRIGGER <= 1'b0;
		end else begin
			O_FIRST_TRIGGER <= trig_next(first_output_timing_reg_ff, seq_is_tx_ff,
				count_ff, O_FIRST_TRIGGER);
			O_SECOND_TRIGGER <= trig_next(second_output_timing_reg_ff, seq_is_tx_ff,
				count_ff, O_SECOND_TRIGGER);
		end
	end

	always_comb begin
		case (I_ADDR)
			ADDR_FIRST_TIMING: nxt_rdata = first_output_timing_reg_ff;
			ADDR_SECOND_TIMING: nxt_rdata = second_output_timing_reg_ff;
			ADDR_END_COUNTS: nxt_rdata = sequence_end_counts_ff;
			ADDR_STATUS: nxt_rdata = {16'h0000, count_ff, le_phase_ff, seq_is_tx_ff,
				proto_ff, seq_ff};
			default: nxt_rdata = 32'h00000000;
		endcase
	end

	always_ff @(posedge I_REF_CLK or negedge I_NRST) begin
		if (!I_NRST) begin
			O_RDATA <= 32'h00000000;
		end else if (I_RD) begin
			O_RDATA <= nxt_rdata;
		end else begin
			O_RDATA <= 32'h00000000;
		end
	end
endmodule

// *** shared/rstg_pkg.sv ***
package rstg_pkg;
	localparam logic [7:0] ADDR_FIRST_TIMING = 8'h00;
	localparam logic [7:0] ADDR_SECOND_TIMING = 8'h04;
	localparam logic [7:0] ADDR_END_COUNTS = 8'h08;
	localparam logic [7:0] ADDR_CONTROL = 8'h0c;
	localparam logic [7:0] ADDR_STATUS = 8'h10;
	localparam logic [31:0] RST_TIMING = 32'hffffffff;
	localparam logic [31:0] RST_END_COUNTS = 32'h6a686f67;
	localparam logic [7:0] QUIET_POINT = 8'hff;
	localparam int CTL_REQ_LE_BIT = 0;
	localparam int CTL_RELEASE_BIT = 1;
	localparam int CTL_WARMDOWN_BIT = 2;

	// Field layout of a timing register and of the end-count register.
	typedef struct packed {
		logic [7:0] rx_deassert;
		logic [7:0] rx_assert;
		logic [7:0] tx_deassert;
		logic [7:0] tx_assert;
	} rstg_timing_t;

	typedef struct packed {
		logic [7:0] rx_warmdown_end_count;
		logic [7:0] rx_warmup_end_count;
		logic [7:0] tx_warmdown_end_count;
		logic [7:0] tx_warmup_end_count;
	} rstg_end_counts_t;

	typedef enum logic [1:0] {
		PROTO_MESH,
		PROTO_HANDOVER,
		PROTO_LE
	} rstg_proto_t;

	typedef enum logic [2:0] {
		SEQ_IDLE,
		SEQ_WARMUP,
		SEQ_ON,
		SEQ_WARMDOWN,
		SEQ_HALT
	} rstg_seq_t;
endpackage

// *** tb/rstg_sva.sv ***
`timescale 1ns/10ps
module rstg_sva (
	input wire logic I_REF_CLK,
	input wire logic I_NRST,
	input wire logic [7:0] I_ADDR,
	input wire logic [31:0] I_WDATA,
	input wire logic I_WR,
	input wire logic I_RD,
	input wire logic [31:0] O_RDATA,
	input wire logic O_FIRST_TRIGGER,
	input wire logic O_SECOND_TRIGGER
);
	logic quiet1_ff;
	logic quiet2_ff;
	default clocking @(posedge I_REF_CLK); endclocking
	default disable iff (!I_NRST);
	// Only an output whose timing word stayed all ones since reset must never rise.
	always_ff @(posedge I_REF_CLK or negedge I_NRST) begin
		if (!I_NRST) begin
			quiet1_ff <= 1'b1;
			quiet2_ff <= 1'b1;
		end else if (I_WR && I_WDATA != 32'hffffffff) begin
			if (I_ADDR == 8'h00)
				quiet1_ff <= 1'b0;
			if (I_ADDR == 8'h04)
				quiet2_ff <= 1'b0;
		end
	end
	sequence wr_then_rd;
		I_WR && I_ADDR < 8'h0c ##1 I_RD && I_ADDR == $past(I_ADDR);
	endsequence
	rd_idle_a: assert property (!I_RD |=> O_RDATA == 32'h0)
		else $error("read data not zero");
	rd_unmapped_a: assert property (I_RD && I_ADDR > 8'h10 |=> O_RDATA == 32'h0)
		else $error("unmapped read not zero");
	wr_readback_a: assert property (wr_then_rd |=> O_RDATA == $past(I_WDATA, 2))
		else $error("readback differs");
	rst_low_a: assert property ($rose(I_NRST) |-> !O_FIRST_TRIGGER && !O_SECOND_TRIGGER)
		else $error("trigger high after reset");
	first_quiet_a: assert property (quiet1_ff |-> !O_FIRST_TRIGGER)
		else $error("first trigger not quiet");
	second_quiet_a: assert property (quiet2_ff |-> !O_SECOND_TRIGGER)
		else $error("second trigger not quiet");
	first_fall_a: assert property ($rose(O_FIRST_TRIGGER) |-> ##[1:300] !O_FIRST_TRIGGER)
		else $error("first trigger stuck");
	second_fall_a: assert property ($rose(O_SECOND_TRIGGER) |-> ##[1:300] !O_SECOND_TRIGGER)
		else $error("second trigger stuck");
endmodule
bind rstg_top rstg_sva rstg_sva_inst (.I_REF_CLK(I_REF_CLK), .I_NRST(I_NRST),
	.I_ADDR(I_ADDR), .I_WDATA(I_WDATA), .I_WR(I_WR), .I_RD(I_RD), .O_RDATA(O_RDATA),
	.O_FIRST_TRIGGER(O_FIRST_TRIGGER), .O_SECOND_TRIGGER(O_SECOND_TRIGGER));

// *** tb/tb_rstg_top.sv ***
`timescale 1ns/10ps
module tb_rstg_top import rstg_pkg::*;;
	logic clk = 1'b0;
	logic nrst = 1'b0;
	logic [7:0] addr = 8'h0;
	logic [31:0] wdata = 32'h0;
	logic wr = 1'b0;
	logic rd = 1'b0;
	logic rd_d = 1'b0;
	logic t1_d = 1'b0;
	logic t2_d = 1'b0;
	logic [31:0] rdata;
	logic trig1;
	logic trig2;
	logic [31:0] exp_q[$];
	int err_count = 0;
	int n_checks = 0;
	int cycles = 0;
	int rise1 = 0;
	int rise2 = 0;
	always #2 clk = ~clk;
	rstg_top rstg_top_inst (.I_REF_CLK(clk), .I_NRST(nrst), .I_ADDR(addr), .I_WDATA(wdata),
		.I_WR(wr), .I_RD(rd), .O_RDATA(rdata), .O_FIRST_TRIGGER(trig1),
		.O_SECOND_TRIGGER(trig2));
	task automatic chk(input string w, input logic [31:0] e, input logic [31:0] g);
		n_checks++;
		if (g !== e) begin
			err_count++;
			$display("unexpected %s expected %h seen %h", w, e, g);
		end
	endtask
	task automatic summarize();
		if (err_count == 0 && n_checks > 0)
			$display("NO MISMATCHES");
		else
			$display("MISMATCHES SEEN");
		$finish;
	endtask
	// For a read, d is the value that the data phase must show.
	task automatic bus(input logic w, input logic [7:0] a, input logic [31:0] d);
		wr <= w;
		rd <= !w;
		addr <= a;
		wdata <= d;
		if (!w)
			exp_q.push_back(d);
		@(posedge clk);
	endtask
	always @(posedge clk) begin
		rd_d <= rd;
		t1_d <= trig1;
		t2_d <= trig2;
		cycles++;
		if (rd_d)
			chk("read data", exp_q.pop_front(), rdata);
		if (trig1 === 1'b1 && t1_d === 1'b0)
			rise1++;
		if (trig2 === 1'b1 && t2_d === 1'b0)
			rise2++;
		if (cycles == 2000) begin
			err_count++;
			summarize();
		end
	end
	initial begin
		logic [31:0] r;
		void'($urandom(32'h12d39695));
		repeat (10) @(posedge clk);
		nrst <= 1'b1;
		@(posedge clk);
		bus(1'b0, ADDR_FIRST_TIMING, RST_TIMING);
		bus(1'b0, ADDR_SECOND_TIMING, RST_TIMING);
		bus(1'b0, ADDR_END_COUNTS, RST_END_COUNTS);
		bus(1'b1, 8'h14, 32'h5a5a5a5a);
		bus(1'b0, 8'h14, 32'h0);
		r = {16'hffff, 16'($urandom)};
		bus(1'b1, ADDR_SECOND_TIMING, r);
		bus(1'b0, ADDR_SECOND_TIMING, r);
		bus(1'b1, ADDR_SECOND_TIMING, 32'h6a69ffff);
		wr <= 1'b0;
		rd <= 1'b0;
		// The mesh receive warm-up must reach its hold before warm-down is honoured.
		repeat (150) @(posedge clk);
		bus(1'b0, ADDR_STATUS, 32'h00006802);
		bus(1'b1, ADDR_CONTROL, 32'h1 << CTL_WARMDOWN_BIT);
		wr <= 1'b0;
		repeat (150) @(posedge clk);
		chk("rx warm-down pulses", 1, rise2);
		bus(1'b1, ADDR_SECOND_TIMING, 32'hffff6f68);
		bus(1'b1, ADDR_CONTROL, 32'h1 << CTL_REQ_LE_BIT);
		wr <= 1'b0;
		repeat (150) @(posedge clk);
		chk("pulses in le receive", 1, rise2);
		bus(1'b1, ADDR_CONTROL, 32'h1 << CTL_WARMDOWN_BIT);
		wr <= 1'b0;
		repeat (150) @(posedge clk);
		bus(1'b1, ADDR_CONTROL, 32'h1 << CTL_WARMDOWN_BIT);
		wr <= 1'b0;
		repeat (40) @(posedge clk);
		chk("tx warm-down pulses", 2, rise2);
		chk("second level", 32'h0, 32'(trig2));
		chk("first pulses", 0, rise1);
		summarize();
	end
endmodule
